//--- core/pccb_defines.vh
// Addresses, field positions, reset values and counts of the config bank.
`ifndef PCCB_DEFINES_VH
`define PCCB_DEFINES_VH

`define PCCB_AW 16
`define PCCB_ADDR_CFG 16'hd170
`define PCCB_ADDR_STAT 16'hd174

`define PCCB_SOFT_RESET_CTL_BIT 10
`define PCCB_READ_ERROR_RESPONSE_SEL_BIT 9
`define PCCB_M0_BIT 8
`define PCCB_M1_BIT 7
`define PCCB_M2_BIT 6
`define PCCB_IO_BIT 5
`define PCCB_TARGET_READY_BIT_BIT 4
`define PCCB_INIT_CFG_ACCESS_ENABLE_BIT 3
`define PCCB_LOAD_SOURCE_SELECT_BIT 2
`define PCCB_EEPROM_LOAD_COMPLETE_BIT 0
`define PCCB_SRSTOK_BIT 16

`define PCCB_READ_ERROR_RESPONSE_SEL_RST 1'h1
`define PCCB_INIT_CFG_ACCESS_ENABLE_RST 1'h1
`define PCCB_M0_RST 1'h0
`define PCCB_M1_RST 1'h0
`define PCCB_IO_RST 1'h0
`define PCCB_LOAD_SOURCE_SELECT_RST 1'h0
`define PCCB_SOFT_RESET_CTL_RST 1'h0

`define PCCB_SOFT_RESET_CTL_MIN_PCI_CLKS 3'h4
`define PCCB_CNT_W 3

`endif

//--- core/pccb_sync.v
// Two-flop synchroniser for a group of levels from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none

module pccb_sync
#(
   parameter WIDTH = 1
)
(
   input wire mclk_i,
   input wire [WIDTH-1:0] async_i,
   output reg [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] stage1;

   always @(posedge mclk_i)
   begin
      stage1 <= async_i;
      sync_o <= stage1;
   end

endmodule // pccb_sync

`default_nettype wire

//--- core/pccb_regs.v
// Controller configuration bits with soft reset, windows and target gating.
//
// What this block does
// - Writing one to soft reset resets the controller and reloads config space.
// - While soft reset is set, other controller registers are inaccessible.
// - Soft reset keeps the status registers and the load-source bit unchanged.
// - With read error response set, initiator read errors give an internal bus error.
// - Window 0 and window 1 enables, reset zero, gate initiator accesses.
// - Window 2 enable gates accesses; resets one in boot mode, else zero.
// - The I/O window enable, reset zero, gates initiator I/O accesses.
// - Target accesses accepted only with target-ready and load flag; else retry.
// - Target-ready resets to one in boot and satellite modes, else zero.
// - Config access enable, reset one, gates configuration cycles.
// - Soft reset loads from config data registers if load-source is one.
// - The EEPROM load flag sets when the internal load process finishes.
`include "pccb_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module pccb_regs
(
   input wire mclk_i,
   input wire reset_i,
   input wire [`PCCB_AW-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   input wire pci_clk_i,
   input wire boot_mode_i,
   input wire satellite_mode_i,
   input wire load_process_done_i,
   input wire init_read_active_i,
   input wire err_data_parity_i,
   input wire err_master_abort_i,
   input wire err_target_abort_i,
   input wire err_trdy_timeout_i,
   input wire err_retry_timeout_i,
   input wire tgt_access_req_i,
   output reg soft_reset_o,
   output reg reload_start_o,
   output reg reload_from_cfgdata_o,
   output reg other_regs_block_o,
   output reg ibus_read_berr_o,
   output reg mem_window0_enable_o,
   output reg mem_window1_enable_o,
   output reg mem_window2_enable_o,
   output reg io_window_enable_o,
   output reg init_cfg_access_enable_o,
   output reg target_accept_o,
   output reg target_retry_o
);

   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   wire [2:0] pins_s;
   wire pci_clk_s;
   wire boot_s;
   wire sat_s;

   pccb_sync #(.WIDTH(3)) u_sync
   (
      .mclk_i(mclk_i),
      .async_i({pci_clk_i, boot_mode_i, satellite_mode_i}),
      .sync_o(pins_s)
   );

   assign pci_clk_s = pins_s[2];
   assign boot_s = pins_s[1];
   assign sat_s = pins_s[0];

   // ==========================================================
   // Register state
   // ==========================================================
   reg soft_reset_ctl;
   reg read_error_response_sel;
   reg target_ready_bit;
   reg load_source_select;
   reg eeprom_load_complete;
   reg strap_boot;
   reg strap_sat;
   reg strap_done;
   reg soft_reset_ctl_q;
   reg pci_clk_q;
   reg [`PCCB_CNT_W-1:0] pci_clk_cnt;
   wire pci_rise;
   wire soft_reset_ctl_min_ok;

   assign pci_rise = pci_clk_s & ~pci_clk_q;
   assign soft_reset_ctl_min_ok = (pci_clk_cnt == `PCCB_SOFT_RESET_CTL_MIN_PCI_CLKS);

   // ==========================================================
   // Bus slave
   // ==========================================================
   wire req;
   wire accept;
   wire sel_cfg;
   wire sel_stat;
   wire cfg_wr_lo;
   wire cfg_wr_hi;
   reg [31:0] next_readdata;
   reg [31:0] cfg_word;
   reg [31:0] stat_word;

   assign req = avs_read_i | avs_write_i;
   // The access is taken at the edge where waitrequest is seen low.
   assign accept = req & ~avs_waitrequest_o;
   assign sel_cfg = (avs_address_i == `PCCB_ADDR_CFG);
   assign sel_stat = (avs_address_i == `PCCB_ADDR_STAT);
   assign cfg_wr_lo = accept & avs_write_i & sel_cfg & avs_byteenable_i[0];
   assign cfg_wr_hi = accept & avs_write_i & sel_cfg & avs_byteenable_i[1];

   always @*
   begin
      cfg_word = 32'h0000_0000;
      cfg_word[`PCCB_SOFT_RESET_CTL_BIT] = soft_reset_ctl;
      cfg_word[`PCCB_READ_ERROR_RESPONSE_SEL_BIT] = read_error_response_sel;
      cfg_word[`PCCB_M0_BIT] = mem_window0_enable_o;
      cfg_word[`PCCB_M1_BIT] = mem_window1_enable_o;
      cfg_word[`PCCB_M2_BIT] = mem_window2_enable_o;
      cfg_word[`PCCB_IO_BIT] = io_window_enable_o;
      cfg_word[`PCCB_TARGET_READY_BIT_BIT] = target_ready_bit;
      cfg_word[`PCCB_INIT_CFG_ACCESS_ENABLE_BIT] = init_cfg_access_enable_o;
      cfg_word[`PCCB_LOAD_SOURCE_SELECT_BIT] = load_source_select;
      stat_word = 32'h0000_0000;
      stat_word[`PCCB_EEPROM_LOAD_COMPLETE_BIT] = eeprom_load_complete;
      stat_word[`PCCB_SRSTOK_BIT] = soft_reset_ctl_min_ok;
      next_readdata = 32'h0000_0000;
      if (sel_cfg)
      begin
         next_readdata = cfg_word;
      end
      else if (sel_stat && !soft_reset_ctl)
      begin
         next_readdata = stat_word;
      end
   end

   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0000_0000;
      end
      else if (req && avs_waitrequest_o)
      begin
         avs_waitrequest_o <= 1'b0;
         avs_readdata_o <= next_readdata;
      end
      else
      begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // ==========================================================
   // Mode straps, caught on the first edge after reset release
   // ==========================================================
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         strap_done <= 1'b0;
         strap_boot <= 1'b0;
         strap_sat <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_done <= 1'b1;
         strap_boot <= boot_s;
         strap_sat <= sat_s;
      end
   end

   // ==========================================================
   // Configuration fields
   // ==========================================================
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         soft_reset_ctl <= `PCCB_SOFT_RESET_CTL_RST;
         load_source_select <= `PCCB_LOAD_SOURCE_SELECT_RST;
         read_error_response_sel <= `PCCB_READ_ERROR_RESPONSE_SEL_RST;
         mem_window0_enable_o <= `PCCB_M0_RST;
         mem_window1_enable_o <= `PCCB_M1_RST;
         mem_window2_enable_o <= 1'b0;
         io_window_enable_o <= `PCCB_IO_RST;
         target_ready_bit <= 1'b0;
         init_cfg_access_enable_o <= `PCCB_INIT_CFG_ACCESS_ENABLE_RST;
      end
      else if (!strap_done)
      begin
         mem_window2_enable_o <= boot_s;
         target_ready_bit <= boot_s | sat_s;
      end
      else
      begin
         if (cfg_wr_hi)
         begin
            soft_reset_ctl <= avs_writedata_i[`PCCB_SOFT_RESET_CTL_BIT];
         end
         // The load-source bit is never touched by soft reset.
         if (cfg_wr_lo)
         begin
            load_source_select <= avs_writedata_i[`PCCB_LOAD_SOURCE_SELECT_BIT];
         end
         if (cfg_wr_hi)
         begin
            read_error_response_sel <= avs_writedata_i[`PCCB_READ_ERROR_RESPONSE_SEL_BIT];
            mem_window0_enable_o <= avs_writedata_i[`PCCB_M0_BIT];
         end
         else if (soft_reset_ctl)
         begin
            read_error_response_sel <= `PCCB_READ_ERROR_RESPONSE_SEL_RST;
            mem_window0_enable_o <= `PCCB_M0_RST;
         end
         if (cfg_wr_lo)
         begin
            mem_window1_enable_o <= avs_writedata_i[`PCCB_M1_BIT];
            mem_window2_enable_o <= avs_writedata_i[`PCCB_M2_BIT];
            io_window_enable_o <= avs_writedata_i[`PCCB_IO_BIT];
            target_ready_bit <= avs_writedata_i[`PCCB_TARGET_READY_BIT_BIT];
            init_cfg_access_enable_o <= avs_writedata_i[`PCCB_INIT_CFG_ACCESS_ENABLE_BIT];
         end
         else if (soft_reset_ctl)
         begin
            mem_window1_enable_o <= `PCCB_M1_RST;
            mem_window2_enable_o <= strap_boot;
            io_window_enable_o <= `PCCB_IO_RST;
            target_ready_bit <= strap_boot | strap_sat;
            init_cfg_access_enable_o <= `PCCB_INIT_CFG_ACCESS_ENABLE_RST;
         end
      end
   end

   // ==========================================================
   // Soft reset sequencing and PCI clock count
   // ==========================================================
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         soft_reset_ctl_q <= 1'b0;
         pci_clk_q <= 1'b0;
         pci_clk_cnt <= {`PCCB_CNT_W{1'b0}};
         soft_reset_o <= 1'b0;
         reload_start_o <= 1'b0;
         reload_from_cfgdata_o <= 1'b0;
         other_regs_block_o <= 1'b0;
      end
      else
      begin
         soft_reset_ctl_q <= soft_reset_ctl;
         pci_clk_q <= pci_clk_s;
         soft_reset_o <= soft_reset_ctl;
         other_regs_block_o <= soft_reset_ctl;
         reload_start_o <= soft_reset_ctl & ~soft_reset_ctl_q;
         if (soft_reset_ctl && !soft_reset_ctl_q)
         begin
            reload_from_cfgdata_o <= load_source_select;
         end
         // Counts PCI clock rises up to four while soft reset is set; status reads give zero then, so only a read latched the cycle after it clears sees it.
         if (!soft_reset_ctl)
         begin
            pci_clk_cnt <= {`PCCB_CNT_W{1'b0}};
         end
         else if (pci_rise && !soft_reset_ctl_min_ok)
         begin
            pci_clk_cnt <= pci_clk_cnt + 1'b1;
         end
      end
   end

   // ==========================================================
   // Load flag, status kept across soft reset
   // ==========================================================
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         eeprom_load_complete <= 1'b0;
      end
      else if (load_process_done_i)
      begin
         eeprom_load_complete <= 1'b1;
      end
   end

   // ==========================================================
   // Initiator read errors and target gating
   // ==========================================================
   wire any_read_err;

   assign any_read_err = err_data_parity_i | err_master_abort_i |
      err_target_abort_i | err_trdy_timeout_i | err_retry_timeout_i;

   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         ibus_read_berr_o <= 1'b0;
         target_accept_o <= 1'b0;
         target_retry_o <= 1'b0;
      end
      else
      begin
         ibus_read_berr_o <= read_error_response_sel & init_read_active_i &
            any_read_err;
         target_accept_o <= target_ready_bit & eeprom_load_complete;
         target_retry_o <= tgt_access_req_i &
            ~(target_ready_bit & eeprom_load_complete);
      end
   end

endmodule // pccb_regs

`default_nettype wire

//--- bench/pccb_pci_agent.sv
// PCI side agent model: free-running bus clock and target access attempts.
`timescale 1ns/1ns
`default_nettype none
module pccb_pci_agent (
   input wire logic req_en_i,
   output logic pci_clk_o,
   output logic tgt_req_o
);
   initial pci_clk_o = 1'b0;
   initial tgt_req_o = 1'b0;
   always
   begin
      #62 pci_clk_o = 1'b1;
      #63 pci_clk_o = 1'b0;
   end
   always @(posedge pci_clk_o) tgt_req_o <= req_en_i;
endmodule // pccb_pci_agent
`default_nettype wire

//--- bench/pccb_regs_sva.sv
// Checker of port relations of the controller config bank.
`timescale 1ns/1ns
`default_nettype none
module pccb_regs_sva (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic init_read_active_i,
   input wire logic err_data_parity_i,
   input wire logic err_master_abort_i,
   input wire logic err_target_abort_i,
   input wire logic err_trdy_timeout_i,
   input wire logic err_retry_timeout_i,
   input wire logic tgt_access_req_i,
   input wire logic soft_reset_o,
   input wire logic reload_start_o,
   input wire logic other_regs_block_o,
   input wire logic ibus_read_berr_o,
   input wire logic mem_window0_enable_o,
   input wire logic io_window_enable_o,
   input wire logic init_cfg_access_enable_o,
   input wire logic target_accept_o,
   input wire logic target_retry_o
);
   wire logic any_err;
   assign any_err = err_data_parity_i | err_master_abort_i |
      err_target_abort_i | err_trdy_timeout_i | err_retry_timeout_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   a_berr_cause: assert property
      (ibus_read_berr_o |-> $past(init_read_active_i && any_err))
      else $error("read bus error without a cause");
   a_wait_one: assert property
      ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer late");
   a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_reload_rise: assert property
      (reload_start_o |-> soft_reset_o && !$past(soft_reset_o))
      else $error("reload pulse off the soft reset rise");
   a_block_soft_reset_ctl: assert property (other_regs_block_o == soft_reset_o)
      else $error("register block differs from soft reset");
   a_retry_cause: assert property
      (target_retry_o |-> $past(tgt_access_req_i) && !target_accept_o)
      else $error("retry without a refused request");
   a_reset_vals: assert property ($past(reset_i) |->
      init_cfg_access_enable_o && !mem_window0_enable_o && !io_window_enable_o)
      else $error("enable reset value wrong");
   a_win_change: assert property (!$stable(mem_window0_enable_o) |->
      $past(avs_write_i && !avs_waitrequest_o) || soft_reset_o || $past(reset_i))
      else $error("window enable changed without cause");
endmodule // pccb_regs_sva
bind pccb_regs pccb_regs_sva chk (.*);
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench of the controller config bank.
`timescale 1ns/1ns
`default_nettype none
`include "pccb_defines.vh"
module tb_top;
   localparam logic [15:0] ac = `PCCB_ADDR_CFG;
   localparam logic [15:0] as = `PCCB_ADDR_STAT;
   logic mclk_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0;
   logic [15:0] avs_address_i = 0;
   logic [31:0] avs_writedata_i = 0, avs_readdata_o, q, d, lc;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [4:0] err = 0;
   logic boot_mode_i = 0, satellite_mode_i = 0, load_process_done_i = 0;
   logic init_read_active_i = 0, req_en = 0, pci_clk_i, tgt_access_req_i;
   logic avs_waitrequest_o, soft_reset_o, reload_start_o, reload_from_cfgdata_o;
   logic other_regs_block_o, ibus_read_berr_o, mem_window0_enable_o;
   logic mem_window1_enable_o, mem_window2_enable_o, io_window_enable_o;
   logic init_cfg_access_enable_o, target_accept_o, target_retry_o;
   integer fails = 0, n_tests = 0, cyc = 0, seed = 59, i;
   always #5 mclk_i = ~mclk_i;
   pccb_pci_agent agent (.req_en_i(req_en), .pci_clk_o(pci_clk_i),
      .tgt_req_o(tgt_access_req_i));
   pccb_regs uut (.*, .err_data_parity_i(err[0]), .err_master_abort_i(err[1]),
      .err_target_abort_i(err[2]), .err_trdy_timeout_i(err[3]),
      .err_retry_timeout_i(err[4]));
   // =========================================================
   // Tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_write_i <= w;
      avs_read_i <= !w;
      // Waitrequest and read data are taken as they stood at the rising edge.
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 0;
      avs_read_i <= 0;
   endtask
   task automatic wt(input integer n);
      repeat (n) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         print_verdict;
      end
   end
   // =========================================================
   // Scenarios
   initial
   begin
      repeat (4) @(posedge mclk_i);
      reset_i <= 0;
      repeat (2) @(posedge mclk_i);
      bus(0, ac, 0); chk("cfg reset", 32'h208, q);
      bus(0, as, 0); chk("load flag", 0, q & 1);
      bus(0, 16'h0000, 0); chk("unmapped", 0, q);
      req_en <= 1;
      wt(40); chk("retry", 1, target_retry_o);
      bus(1, ac, 32'h210);
      wt(40); chk("retry no load", 1, target_retry_o);
      @(posedge mclk_i) load_process_done_i <= 1;
      @(posedge mclk_i) load_process_done_i <= 0;
      wt(40); chk("accept", 1, target_accept_o);
      chk("no retry", 0, target_retry_o);
      bus(0, as, 0); chk("load done", 1, q & 1);
      for (i = 0; i < 8; i++)
      begin
         d = (i == 0 ? 32'hffffffff : $random(seed)) & 32'hfffffbff | 32'h10;
         bus(1, ac, d);
         wt(0); chk("windows", {d[8:5], d[3]}, {mem_window0_enable_o,
            mem_window1_enable_o, mem_window2_enable_o, io_window_enable_o,
            init_cfg_access_enable_o});
         bus(0, ac, 0); chk("cfg rw", d & 32'h3fc, q);
      end
      bus(1, ac, 32'h210);
      for (i = 0; i < 5; i++)
      begin
         @(posedge mclk_i) err <= 5'h1 << i;
         init_read_active_i <= 1;
         wt(2); chk("berr", 1, ibus_read_berr_o);
      end
      bus(1, ac, 32'h010);
      wt(2); chk("berr off", 0, ibus_read_berr_o);
      @(posedge mclk_i) err <= 0;
      for (i = 0; i < 2; i++)
      begin
         lc = i ? 32'h0 : 32'h4;
         bus(1, ac, lc | 32'h210);
         bus(1, ac, lc | 32'h510);
         // The soft reset output follows the control bit one cycle later.
         wt(1); chk("soft_reset_ctl", 1, soft_reset_o);
         chk("src", lc[2], reload_from_cfgdata_o);
         bus(0, ac, 0); chk("cfg soft_reset_ctl", 32'h608 | lc, q);
         bus(0, as, 0); chk("blocked", 0, q);
         wt(60);
         bus(1, ac, lc | 32'h210);
         bus(0, as, 0); chk("flag kept", 1, q & 1);
         wt(0); chk("soft_reset_ctl off", 0, soft_reset_o);
      end
      print_verdict;
   end
endmodule // tb_top
`default_nettype wire
